/* File: bench/spi_peer_model.sv */
// Purpose: Behavioural serial slave on the far side of the port
// Assumes: Serial clock far slower than the peripheral clock
// Notes:   Released output line toggles every clock cycle
`timescale 1ns/1ps
module spi_peer_model (
  input  wire logic       clk,
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  input  wire logic       clock_polarity,
  input  wire logic       clock_phase,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic      [7:0] rx_byte
);
  logic [3:0] lead_n  = 4'h0;
  logic [3:0] trail_n = 4'h0;
  logic       pat     = 1'b0;
  logic       sck_q   = 1'b0;
  logic [2:0] idx;

  always @(sck or sel_n) begin
    if (sel_n) begin
      lead_n = 4'h0;
      trail_n = 4'h0;
    end else if (sck != sck_q && sck != clock_polarity) begin
      lead_n = lead_n + 4'h1;
      if (!clock_phase)
        rx_byte = {rx_byte[6:0], mosi};
    end else if (sck != sck_q) begin
      trail_n = trail_n + 4'h1;
      if (clock_phase)
        rx_byte = {rx_byte[6:0], mosi};
    end
    sck_q = sck;
  end

  // MSB before first edge or on it
  // index wraps per byte under held select
  assign idx = clock_phase ? 3'(4'h8 - lead_n) : 3'(4'h7 - trail_n);
  // released line shows no stale bit
  always @(posedge clk) pat <= ~pat;
  assign miso = sel_n ? pat : tx_byte[idx];
endmodule

/* File: bench/tb_top.sv */
// Purpose: Self-checking bench for the byte-wide serial port
// Assumes: Peer slave model in master tests
// Notes:   Bench plays the external master in slave tests
`timescale 1ns/1ps
module tb_top
  import spi_port_pkg::*;
;
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] d;
    logic [7:0] pd;
    logic       coll;
    logic [7:0] half;
  } row_t;
  localparam int WR_CTL = 0;
  localparam int RD_STA = 1;
  localparam int WR_DAT = 2;
  localparam int RD_DAT = 3;
  localparam row_t ROWS [6] = '{
    '{8'h51, 8'ha5, 8'h3c, 1'b0, 8'h02},
    '{8'h56, 8'h81, 8'h7e, 1'b1, 8'h04},
    '{8'h5b, 8'h01, 8'h80, 1'b0, 8'h08},
    '{8'hdc, 8'hfe, 8'h7f, 1'b1, 8'h10},
    '{8'hd1, 8'hc3, 8'h96, 1'b0, 8'h20},
    '{8'hd6, 8'h5a, 8'he1, 1'b0, 8'h40}};

  logic       clk        = 1'b0;
  logic       rst_n      = 1'b0;
  logic       ctrl_wr    = 1'b0;
  logic       stat_rd    = 1'b0;
  logic       data_wr    = 1'b0;
  logic       data_rd    = 1'b0;
  logic [7:0] ctrl_wdata = 8'h00;
  logic [7:0] data_wdata = 8'h00;
  logic       ss_n       = 1'b1;
  logic       m_sck      = 1'b0;
  logic       m_mosi     = 1'b0;
  logic       peer_sel_n = 1'b1;
  logic [7:0] peer_tx    = 8'h00;
  logic [7:0] pctl       = 8'h00;
  logic [7:0] cur        = 8'h14;
  logic [7:0] ctrl_q, stat_q, data_q, peer_rx;
  logic       irq_tx, irq_rx, sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, p_miso;
  int         fail_count = 0;
  int         num_checks = 0;
  int         cyc        = 0;
  wire        sck_w  = sck_oe ? sck_o : m_sck;
  wire        mosi_w = mosi_oe ? mosi_o : m_mosi;
  wire        miso_w = miso_oe ? miso_o : p_miso;

  spi_master_slave_port spi_master_slave_port_i (
    .CLK(clk), .RST_N(rst_n), .CTRL_WR(ctrl_wr), .CTRL_WDATA(ctrl_wdata),
    .STAT_RD(stat_rd), .DATA_WR(data_wr), .DATA_WDATA(data_wdata), .DATA_RD(data_rd),
    .CTRL_Q(ctrl_q), .STAT_Q(stat_q), .DATA_Q(data_q), .IRQ_TX(irq_tx), .IRQ_RX(irq_rx),
    .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE(sck_oe), .MOSI_I(mosi_w), .MOSI_O(mosi_o),
    .MOSI_OE(mosi_oe), .MISO_I(miso_w), .MISO_O(miso_o), .MISO_OE(miso_oe), .SS_N_I(ss_n));

  spi_peer_model spi_peer_model_i (
    .clk(clk), .sck(sck_w), .mosi(mosi_w), .sel_n(peer_sel_n), .clock_polarity(pctl[CTL_CLOCK_POLARITY]),
    .clock_phase(pctl[CTL_CLOCK_PHASE]), .tx_byte(peer_tx), .miso(p_miso), .rx_byte(peer_rx));

  always #2 clk = ~clk;

  task automatic report_and_stop;
    if (fail_count == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic acc(input int k, input logic [7:0] d);
    @(posedge clk);
    ctrl_wr <= (k == WR_CTL);
    stat_rd <= (k == RD_STA);
    data_wr <= (k == WR_DAT);
    data_rd <= (k == RD_DAT);
    ctrl_wdata <= d;
    data_wdata <= d;
    @(posedge clk);
    {ctrl_wr, stat_rd, data_wr, data_rd} <= 4'h0;
  endtask

  // disable before polarity or phase change
  task automatic setctl(input logic [7:0] v);
    acc(WR_CTL, cur & 8'hbf);
    acc(WR_CTL, v & 8'hbf);
    acc(WR_CTL, v);
    cur = v;
  endtask

  task automatic mxfer(input row_t r, input logic [7:0] ed);
    int   n;
    int   edges;
    int   first;
    int   h;
    logic s;
    setctl(r.ctl);
    @(posedge clk);
    peer_tx <= r.pd;
    pctl <= r.ctl;
    // select per byte, after clock settles
    @(posedge clk);
    peer_sel_n <= 1'b0;
    acc(WR_DAT, r.d);
    chk("idle sck", {7'h0, r.ctl[CTL_CLOCK_POLARITY]}, {7'h0, sck_o});
    n = 0;
    edges = 0;
    first = 0;
    h = 0;
    s = sck_o;
    while (edges < 16 && n < 3000) begin
      @(posedge clk);
      n++;
      data_wr <= r.coll && n == 10;
      data_wdata <= ~r.d;
      if (sck_o !== s) begin
        edges++;
        if (edges == 1)
          first = n;
        if (edges == 2)
          h = n - first;
      end
      s = sck_o;
    end
    repeat (3) @(posedge clk);
    peer_sel_n <= 1'b1;
    @(negedge clk);
    chk("edges", 8'h10, 8'(edges));
    chk("half period", r.half, 8'(h));
    chk("idle sck", {7'h0, r.ctl[CTL_CLOCK_POLARITY]}, {7'h0, sck_o});
    chk("data", ed, data_q);
    chk("peer data", r.d, peer_rx);
    chk("status", {1'b1, r.coll, 6'h0}, stat_q);
    chk("irq", 8'h02, {6'h0, irq_tx, irq_rx});
  endtask

  task automatic sxfer(input logic clock_phase, input logic [7:0] dd, input logic [7:0] dm);
    logic [7:0] got;
    setctl({5'h08, clock_phase, 2'h0});
    acc(WR_DAT, dd);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      m_sck <= ~m_sck;
    end
    @(negedge clk);
    chk("oe", 8'h00, {5'h0, sck_oe, mosi_oe, miso_oe});
    chk("status", 8'h00, stat_q);
    @(posedge clk);
    m_mosi <= dm[7];
    ss_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      repeat (4) @(posedge clk);
      if (!clock_phase)
        got[i] = miso_w;
      m_sck <= 1'b1;
      if (clock_phase)
        m_mosi <= dm[i];
      repeat (4) @(posedge clk);
      if (clock_phase)
        got[i] = miso_w;
      m_sck <= 1'b0;
      if (!clock_phase && i > 0)
        m_mosi <= dm[i-1];
    end
    repeat (4) @(posedge clk);
    ss_n <= 1'b1;
    m_mosi <= ~m_mosi;
    repeat (2) @(negedge clk);
    chk("slave out", dd, got);
    chk("slave in", dm, data_q);
    chk("status", 8'h80, stat_q);
    chk("miso oe", 8'h00, {7'h0, miso_oe});
    acc(RD_STA, 8'h00);
    acc(RD_DAT, 8'h00);
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("ctrl", 8'h14, ctrl_q);
    chk("oe irq", 8'h00, {3'h0, sck_oe, mosi_oe, miso_oe, irq_tx, irq_rx});
    foreach (ROWS[k]) begin
      mxfer(ROWS[k], ROWS[k].pd);
      acc(RD_STA, 8'h00);
      acc(RD_DAT, 8'h00);
      @(negedge clk);
      chk("status", 8'h00, stat_q);
    end
    mxfer(ROWS[0], ROWS[0].pd);
    mxfer(ROWS[2], ROWS[0].pd);
    acc(RD_STA, 8'h00);
    acc(RD_DAT, 8'h00);
    setctl(8'h51);
    ss_n <= 1'b0;
    repeat (4) @(negedge clk);
    chk("status", 8'h10, stat_q);
    chk("ctrl", 8'h01, ctrl_q);
    chk("irq rx", 8'h01, {7'h0, irq_rx});
    @(posedge clk);
    ss_n <= 1'b1;
    setctl(8'h21);
    @(negedge clk);
    chk("status", 8'h10, stat_q);
    chk("irq rx", 8'h00, {7'h0, irq_rx});
    acc(RD_STA, 8'h00);
    acc(WR_CTL, 8'h21);
    @(negedge clk);
    chk("status", 8'h00, stat_q);
    setctl(8'h71);
    ss_n <= 1'b0;
    repeat (4) @(negedge clk);
    chk("status", 8'h00, stat_q);
    chk("ctrl", 8'h71, ctrl_q);
    @(posedge clk);
    ss_n <= 1'b1;
    // reserved rate code, no serial clock
    setctl(8'h50);
    acc(WR_DAT, 8'h3c);
    repeat (40) @(posedge clk);
    acc(WR_DAT, 8'h3c);
    @(negedge clk);
    chk("bad rate", 8'h40, {stat_q[7:1], sck_o});
    acc(RD_STA, 8'h00);
    acc(RD_DAT, 8'h00);
    sxfer(1'b0, 8'hb4, 8'h2d);
    sxfer(1'b1, 8'h69, 8'hc6);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(negedge clk);
    chk("ctrl", 8'h14, ctrl_q);
    chk("status", 8'h00, stat_q);
    report_and_stop();
  end
endmodule

/* File: rtl/rate_link_if.sv */
// Purpose: Link between transfer core and serial clock rate generator
// Assumes: Same clock on both sides
// Notes:   Tick marks each serial clock edge time
`timescale 1ns/1ps
interface rate_link_if;
  logic       run;
  logic [2:0] code;
  logic       tick;

  modport gen  (input run, input code, output tick);
  modport core (output run, output code, input tick);
endinterface

/* File: rtl/sck_rate_gen.sv */
// Purpose: Serial clock half-period tick generator for master mode
// Assumes: Run held high for the whole master transfer
// Notes:   Invalid rate codes give no tick at all
`timescale 1ns/1ps
module sck_rate_gen
  import spi_port_pkg::*;
(
  input wire logic   clk,
  input wire logic   rst_n,
  rate_link_if.gen   lnk
);

  logic [6:0] cnt_r;
  logic       tick_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 7'h00;
    end else if (!lnk.run || cnt_r == 7'(half_period(lnk.code) - 7'h01)) begin
      cnt_r <= 7'h00;
    end else begin
      cnt_r <= 7'(cnt_r + 7'h01);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_r <= 1'b0;
    end else begin
      tick_r <= lnk.run && rate_valid(lnk.code) && (cnt_r == 7'(half_period(lnk.code) - 7'h01));
    end
  end

  assign lnk.tick = tick_r;

  chk_tick_rate_ok: assert property (@(posedge clk) disable iff (!rst_n)
    tick_r |-> rate_valid($past(lnk.code)))
    else $error("tick produced for invalid rate code");

endmodule

/* File: rtl/spi_master_slave_port.sv */
// Purpose: Byte-wide full-duplex serial port, master or slave
// Assumes: Pins synchronous to CLK; register access by strobes
// Notes:   Two-way pins split into input, output and enable
`timescale 1ns/1ps
module spi_master_slave_port
  import spi_port_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic       CTRL_WR,
  input  wire logic [7:0] CTRL_WDATA,
  input  wire logic       STAT_RD,
  input  wire logic       DATA_WR,
  input  wire logic [7:0] DATA_WDATA,
  input  wire logic       DATA_RD,
  output logic      [7:0] CTRL_Q,
  output logic      [7:0] STAT_Q,
  output logic      [7:0] DATA_Q,
  output logic            IRQ_TX,
  output logic            IRQ_RX,
  input  wire logic       SCK_I,
  output logic            SCK_O,
  output logic            SCK_OE,
  input  wire logic       MOSI_I,
  output logic            MOSI_O,
  output logic            MOSI_OE,
  input  wire logic       MISO_I,
  output logic            MISO_O,
  output logic            MISO_OE,
  input  wire logic       SS_N_I
);

  rate_link_if rlink ();

  xfer_state_t state_r;
  xfer_state_t state_nxt;
  logic [7:0]  ctrl_r;
  logic [7:0]  ctrl_nxt;
  logic [7:0]  shreg_r;
  logic [7:0]  shreg_nxt;
  logic [7:0]  rxbuf_r;
  logic [7:0]  rx_byte;
  logic [3:0]  cnt_r;
  logic        rx_bit_r;
  logic        sck_prev_r;
  logic        ss_prev_r;
  logic        done_r;
  logic        write_collision_flag_r;
  logic        write_collision_flag_arm_r;
  logic        mode_fault_flag_r;
  logic        mode_fault_flag_nxt;
  logic        mode_fault_flag_arm_r;
  logic        done_arm_r;
  logic        sck_o_r;
  logic        sck_oe_r;
  logic        dout_r;
  logic        mosi_oe_r;
  logic        miso_oe_r;
  logic        irq_rx_r;

  logic        en;
  logic        master_select;
  logic        clock_polarity;
  logic        clock_phase;
  logic        select_disable;
  logic        is_master;
  logic        slave_sel;
  logic        busy;
  logic        mode_fault_flag_set;
  logic        m_start;
  logic        s_start;
  logic        edge_ev;
  logic        lead;
  logic        sample_ev;
  logic        shift_ev;
  logic        done;
  logic        in_bit;
  logic        abort;
  logic        done_clr;

  assign en        = ctrl_r[CTL_ENABLE];
  assign master_select      = ctrl_r[CTL_MASTER];
  assign clock_polarity      = ctrl_r[CTL_CLOCK_POLARITY];
  assign clock_phase      = ctrl_r[CTL_CLOCK_PHASE];
  assign select_disable     = ctrl_r[CTL_SELECT_DISABLE];
  assign is_master = en && master_select;
  // in slave mode select disable only honoured with phase one
  assign slave_sel = en && !master_select && (!SS_N_I || (select_disable && clock_phase));
  assign busy      = (state_r == ST_XFER);
  assign in_bit    = master_select ? MISO_I : MOSI_I;
  assign lead      = !cnt_r[0];

  assign mode_fault_flag_set  = master_select && !select_disable && !SS_N_I;

  assign m_start   = DATA_WR && is_master && !busy && !mode_fault_flag_set;
  // select fall starts phase zero slave
  // first edge starts phase one slave
  assign s_start   = slave_sel && !busy &&
                     (clock_phase ? (SCK_I != sck_prev_r) : (ss_prev_r && !SS_N_I));

  assign abort     = !en || (master_select && mode_fault_flag_set) || (!master_select && !slave_sel);

  // one edge source for both directions
  always_comb begin
    edge_ev = 1'b0;
    if (is_master) begin
      edge_ev = busy && rlink.tick;
    end else if (slave_sel && (busy || clock_phase)) begin
      edge_ev = (SCK_I != sck_prev_r);
    end
  end

  assign sample_ev = edge_ev && (clock_phase ? !lead : lead);
  assign shift_ev  = edge_ev && (clock_phase ? (lead && cnt_r != 4'h0) : !lead);
  assign done      = edge_ev && (cnt_r == LAST_EDGE) && !abort;
  // received bits enter at the bottom, MSB first
  assign rx_byte   = {shreg_r[6:0], (clock_phase ? in_bit : rx_bit_r)};

  assign rlink.run  = is_master && busy;
  assign rlink.code = {ctrl_r[CTL_RATE2], ctrl_r[CTL_RATE1], ctrl_r[CTL_RATE0]};

  sck_rate_gen u_rate (
    .clk   (CLK),
    .rst_n (RST_N),
    .lnk   (rlink.gen)
  );

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (m_start || s_start) begin
          state_nxt = ST_XFER;
        end
      end
      ST_XFER: begin
        if (abort || done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_r <= 4'h0;
    end else if (state_nxt == ST_IDLE && !(s_start && edge_ev)) begin
      cnt_r <= 4'h0;
    end else if (edge_ev) begin
      cnt_r <= 4'(cnt_r + 4'h1);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_bit_r <= 1'b0;
    end else if (sample_ev) begin
      rx_bit_r <= in_bit;
    end
  end

  // write during transfer leaves the shifter alone
  always_comb begin
    shreg_nxt = shreg_r;
    if (DATA_WR && !busy && !(s_start && edge_ev)) begin
      shreg_nxt = DATA_WDATA;
    end else if (done) begin
      shreg_nxt = rx_byte;
    end else if (shift_ev) begin
      shreg_nxt = {shreg_r[6:0], rx_bit_r};
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      shreg_r <= 8'h00;
      dout_r  <= 1'b0;
    end else begin
      shreg_r <= shreg_nxt;
      // MSB first; held over the closing edge
      dout_r  <= done ? dout_r : shreg_nxt[7];
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sck_prev_r <= 1'b0;
      ss_prev_r  <= 1'b1;
    end else begin
      sck_prev_r <= SCK_I;
      ss_prev_r  <= SS_N_I;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sck_o_r <= 1'b0;
    end else if (!busy || !is_master) begin
      sck_o_r <= clock_polarity;
    end else if (edge_ev) begin
      sck_o_r <= !sck_o_r;
    end
  end

  // lines driven only by master or selected slave
  // slave output released with select high, except with select disable and phase one
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sck_oe_r  <= 1'b0;
      mosi_oe_r <= 1'b0;
      miso_oe_r <= 1'b0;
    end else begin
      sck_oe_r  <= is_master && !mode_fault_flag_set;
      mosi_oe_r <= is_master && !mode_fault_flag_set;
      miso_oe_r <= slave_sel;
    end
  end

  // mode fault drops enable and master bits
  always_comb begin
    ctrl_nxt = CTRL_WR ? CTRL_WDATA : ctrl_r;
    if (mode_fault_flag_set) begin
      ctrl_nxt[CTL_ENABLE] = 1'b0;
      ctrl_nxt[CTL_MASTER] = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_r <= CTL_RESET;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // status read seen, then control write clears
  always_comb begin
    mode_fault_flag_nxt = mode_fault_flag_r;
    if (mode_fault_flag_set) begin
      mode_fault_flag_nxt = 1'b1;
    end else if (CTRL_WR && mode_fault_flag_arm_r) begin
      mode_fault_flag_nxt = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode_fault_flag_r     <= 1'b0;
      mode_fault_flag_arm_r <= 1'b0;
    end else begin
      mode_fault_flag_r <= mode_fault_flag_nxt;
      if (CTRL_WR) begin
        mode_fault_flag_arm_r <= 1'b0;
      end else if (STAT_RD && mode_fault_flag_r) begin
        mode_fault_flag_arm_r <= 1'b1;
      end
    end
  end

  // status access then data access clears
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      write_collision_flag_r     <= 1'b0;
      write_collision_flag_arm_r <= 1'b0;
    end else begin
      if (DATA_WR && busy) begin
        write_collision_flag_r <= 1'b1;
      end else if ((DATA_WR || DATA_RD) && write_collision_flag_arm_r) begin
        write_collision_flag_r <= 1'b0;
      end
      if (DATA_WR || DATA_RD) begin
        write_collision_flag_arm_r <= 1'b0;
      end else if (STAT_RD && write_collision_flag_r) begin
        write_collision_flag_arm_r <= 1'b1;
      end
    end
  end

  assign done_clr = (DATA_WR || DATA_RD) && done_arm_r;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      done_r     <= 1'b0;
      done_arm_r <= 1'b0;
    end else begin
      if (done) begin
        done_r <= 1'b1;
      end else if (done_clr) begin
        done_r <= 1'b0;
      end
      if (DATA_WR || DATA_RD) begin
        done_arm_r <= 1'b0;
      end else if (STAT_RD && done_r) begin
        done_arm_r <= 1'b1;
      end
    end
  end

  // keep first byte while done flag set
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rxbuf_r <= 8'h00;
    end else if (done && !done_r) begin
      rxbuf_r <= rx_byte;
    end
  end

  // error request gated by select disable
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      irq_rx_r <= 1'b0;
    end else begin
      irq_rx_r <= mode_fault_flag_nxt && !ctrl_nxt[CTL_SELECT_DISABLE];
    end
  end

  assign CTRL_Q  = ctrl_r;
  assign STAT_Q  = {done_r, write_collision_flag_r, 1'b0, mode_fault_flag_r, 4'h0};
  assign DATA_Q  = rxbuf_r;
  assign IRQ_TX  = done_r;
  assign IRQ_RX  = irq_rx_r;
  assign SCK_O   = sck_o_r;
  assign SCK_OE  = sck_oe_r;
  assign MOSI_O  = dout_r;
  assign MOSI_OE = mosi_oe_r;
  assign MISO_O  = dout_r;
  assign MISO_OE = miso_oe_r;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  chk_done_sets_flag: assert property (done |=> done_r && IRQ_TX)
    else $error("completion did not set done flag");
  chk_mode_fault_flag_disables: assert property (mode_fault_flag_set |=> mode_fault_flag_r && !CTRL_Q[CTL_ENABLE] && !CTRL_Q[CTL_MASTER])
    else $error("mode fault did not disable port");
  chk_mode_fault_flag_detect: assert property (master_select && !select_disable && !SS_N_I |=> mode_fault_flag_r)
    else $error("select low in master mode missed");
  chk_select_disable_masks: assert property (select_disable && !mode_fault_flag_r |=> !mode_fault_flag_r)
    else $error("mode fault set with select disabled");
  chk_mode_fault_flag_sticky: assert property (mode_fault_flag_r && !(CTRL_WR && mode_fault_flag_arm_r) |=> mode_fault_flag_r)
    else $error("mode fault cleared without sequence");
  chk_error_irq: assert property (IRQ_RX == (mode_fault_flag_r && !select_disable))
    else $error("error request mismatch");
  chk_write_collision_flag_set: assert property (DATA_WR && busy |=> write_collision_flag_r)
    else $error("write collision not flagged");
  chk_write_collision_flag_no_harm: assert property (DATA_WR && busy && !edge_ev && !abort |=> $stable(shreg_r) && busy)
    else $error("collision disturbed transfer");
  chk_rxbuf_hold: assert property (done_r && !done_clr |=> $stable(rxbuf_r))
    else $error("receive buffer overwritten");
  chk_msb_first: assert property (shift_ev && !done && !DATA_WR |=> shreg_r[7:1] == $past(shreg_r[6:0]))
    else $error("shift order wrong");
  chk_slave_quiet: assert property (en && !master_select && SS_N_I && !(select_disable && clock_phase) |=> !MISO_OE)
    else $error("slave drives output while unselected");
  chk_sck_idle: assert property ((!busy && $stable(ctrl_r))[*2] |-> SCK_O == clock_polarity)
    else $error("serial clock not at idle level");

  cov_master_byte: cover property (is_master && done);
  cov_slave_byte: cover property (!master_select && done);
  cov_collision: cover property (DATA_WR && busy);
  cov_mode_fault: cover property (mode_fault_flag_set && busy);

endmodule

/* File: rtl/spi_port_pkg.sv */
// Purpose: Shared constants and types of the serial port
// Assumes: Single clock domain, byte-wide transfers
// Notes:   Control and status layouts as seen on the register ports
package spi_port_pkg;

  // Control register field positions
  localparam int unsigned CTL_RATE2  = 7;
  localparam int unsigned CTL_ENABLE = 6;
  localparam int unsigned CTL_SELECT_DISABLE  = 5;
  localparam int unsigned CTL_MASTER = 4;
  localparam int unsigned CTL_CLOCK_POLARITY   = 3;
  localparam int unsigned CTL_CLOCK_PHASE   = 2;
  localparam int unsigned CTL_RATE1  = 1;
  localparam int unsigned CTL_RATE0  = 0;
  localparam logic [7:0]  CTL_RESET  = 8'h14;

  // Status register field positions
  localparam int unsigned STA_DONE   = 7;
  localparam int unsigned STA_WRITE_COLLISION_FLAG   = 6;
  localparam int unsigned STA_MODE_FAULT_FLAG   = 4;

  // Edges of one byte: eight clock cycles, two edges each
  localparam logic [3:0]  LAST_EDGE  = 4'hf;
  localparam logic [2:0]  RATE_BAD_LO = 3'h0;
  localparam logic [2:0]  RATE_BAD_HI = 3'h7;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_XFER = 2'b01
  } xfer_state_t;

  // Half period of the serial clock in peripheral cycles
  function automatic logic [6:0] half_period(input logic [2:0] code);
    half_period = 7'(7'h01 << code);
  endfunction

  function automatic logic rate_valid(input logic [2:0] code);
    rate_valid = (code != RATE_BAD_LO) && (code != RATE_BAD_HI);
  endfunction

endpackage
